// >>> pical_consts.vh
// offsets, field positions, reset values and timing counts of the input change logic
`ifndef PICAL_CONSTS_VH
`define PICAL_CONSTS_VH

// register offsets on the serial register file
`define PICAL_ADDR_PORT_ONE   8'h01
`define PICAL_ADDR_PORT_FOUR  8'h04
`define PICAL_ADDR_CFG_ALERT  8'h26
`define PICAL_ADDR_CFG_CLOCK  8'h27

// port control register fields
`define PICAL_P_DIR     7
`define PICAL_P_INTEN   5
`define PICAL_P_DEB     2
`define PICAL_P_CHG     1
`define PICAL_P_LVL     0

// alert configuration register fields
`define PICAL_C_PORTRST 0
`define PICAL_C_CNTRST  1
`define PICAL_C_ALERT   6
`define PICAL_C_GCHG    7

// clock configuration register fields
`define PICAL_K_ALERTSEL 0
`define PICAL_K_EXTCLK   2
`define PICAL_K_CLKOUT   3

// reset values
`define PICAL_PORT_RST   8'h80
`define PICAL_CFGA_RST   6'h00
`define PICAL_CFGK_RST   8'h00

// timing
`define PICAL_CLK_FREQ_HZ   100000000
`define PICAL_OSC_FREQ_HZ   32768
`define PICAL_OSC_HALF      11'h5F5 // clock cycles per oscillator half period
`define PICAL_DEB_TIME_US   31000
`define PICAL_DEB_TICKS     ((`PICAL_DEB_TIME_US * `PICAL_OSC_FREQ_HZ) / 1000000)

`endif

// >>> pical_sync.v
// two flip-flop synchroniser for pins entering the clock domain
module pical_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);

   reg [W-1:0] meta;

   // first stage feeds only the second
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta <= {W{1'b0}};
         q    <= {W{1'b0}};
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// >>> pical_debounce.v
// one port's debounce: two equal samples in a row update the stored level
module pical_debounce (
   input  wire clk,
   input  wire rst_n,
   input  wire tick,
   input  wire raw,
   output reg  level
);

   reg prev;

   // sample on each debounce tick, commit only when two samples agree
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev  <= 1'b0;
         level <= 1'b0;
      end
      else if (tick)
      begin
         prev <= raw;
         if (raw == prev)
            level <= raw;
      end
   end

endmodule

// >>> pical_top.v
// input change detection, alert latch, hardware reset and timing clock select
//
// Functional notes
// - debounce samples every 31ms, needs agreement
// - debounced port reads return stored level
// - change detection uses debounced level
// - input change sets port change bit
// - read latches snapshot; mismatch sets change
// - enable bit gates alert, not flag
// - change during read window is lost
// - output ports never detect or alert
// - alert deferred to stop during reads
// - alert status bit equals alert pin
// - global change bit is NOR of ports
// - change sets versus last read, clears
// - global bit sets after all reads
// - hardware reset aborts and forces stop
// - hardware reset doubles as chip enable
// - reset optionally restores ports, counters
// - hardware reset leaves alert untouched
// - port one latching alert, port read releases
// - oscillator always times debounce
// - config selects clock in and out
// - direction, debounce and level bit layout
`include "pical_consts.vh"

module pical_top #(
   parameter DEB_TICKS = `PICAL_DEB_TICKS
) (
   // clock and power-on reset
   input  wire       CLK,
   input  wire       RST_N,
   // hardware reset pin
   input  wire       HW_RST_N,
   output wire       BUS_HOLD_STOP,
   // register access from the serial engine
   input  wire [7:0] REG_ADDR,
   input  wire       REG_WR,
   input  wire [7:0] REG_WDATA,
   input  wire       REG_RD,
   input  wire       BUS_STOP,
   output reg  [7:0] REG_RDATA,
   // port pins
   input  wire [3:0] PORT_IN,
   output reg  [3:0] PORT_OUT,
   output reg  [3:0] PORT_OE_N,
   // waveform generator link
   input  wire [3:0] PWM_LEVEL,
   output reg        TIMING_CLK_TICK,
   output reg        TIMING_CNT_CLEAR
);

   localparam [10:0] OSC_HALF  = `PICAL_OSC_HALF;
   localparam [9:0]  DEB_LAST  = DEB_TICKS[9:0] - 10'h001;

   integer i, i_chg, i_alt, i_rd, i_pin; // one index per process, so one driver each

   // synchronised pins
   wire [4:0] sync_q;
   wire [3:0] raw;
   wire       hw_on;

   pical_sync #(.W (5)) u_sync (
      .clk   (CLK),
      .rst_n (RST_N),
      .d     ({HW_RST_N, PORT_IN}),
      .q     (sync_q)
   );

   assign raw   = sync_q[3:0];
   assign hw_on = sync_q[4];
   // hardware reset low keeps the serial side parked in stop
   assign BUS_HOLD_STOP = ~hw_on;

   // registers
   reg [7:0] port_reg [0:3];
   reg [5:0] cfg_alert;
   reg [7:0] cfg_clock;
   // detection state
   reg [3:0] snap, change, defer;
   reg       alert, in_read_seq, rd_q;
   // timing state
   reg [10:0] osc_cnt;
   reg [9:0]  deb_cnt;
   reg        osc_lvl, osc_prev, deb_tick, sel_prev;
   // decoded per-port terms
   wire [3:0] is_in, deb_en, int_en, deb_val, det, port_hit, set_cond, evt_mask;

   wire alert_sel = cfg_clock[`PICAL_K_ALERTSEL];
   wire ext_sel   = cfg_clock[`PICAL_K_EXTCLK];
   wire clk_out   = cfg_clock[`PICAL_K_CLKOUT];
   wire rd_rise   = REG_RD & ~rd_q;
   wire port_read = rd_rise & (|port_hit);
   wire stop_evt  = BUS_STOP | (~hw_on & in_read_seq);
   wire sel_lvl   = ext_sel ? raw[1] : osc_lvl;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_port
         assign is_in[g]    = port_reg[g][`PICAL_P_DIR] | ((g == 1) && ext_sel);
         assign deb_en[g]   = port_reg[g][`PICAL_P_DEB];
         assign int_en[g]   = port_reg[g][`PICAL_P_INTEN];
         // debounced level replaces the pin for detection and reads
         assign det[g]      = deb_en[g] ? deb_val[g] : raw[g];
         assign port_hit[g] = ({24'h000000, REG_ADDR} == g + 1);
         // a new change: input differs from snapshot, outside its read window
         assign set_cond[g] = is_in[g] & (det[g] != snap[g]) & ~change[g]
                              & ~(REG_RD & port_hit[g]);
         assign evt_mask[g] = set_cond[g] & int_en[g];

         pical_debounce u_deb (
            .clk   (CLK),
            .rst_n (RST_N),
            .tick  (deb_tick),
            .raw   (raw[g]),
            .level (deb_val[g])
         );
      end
   endgenerate

   // internal 32 kHz oscillator and the debounce interval derived from it
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         osc_cnt  <= 11'h000;
         osc_lvl  <= 1'b0;
         osc_prev <= 1'b0;
         deb_cnt  <= 10'h000;
         deb_tick <= 1'b0;
      end
      else
      begin
         osc_prev <= osc_lvl;
         deb_tick <= 1'b0;
         if (osc_cnt == OSC_HALF - 11'h001)
         begin
            osc_cnt <= 11'h000;
            osc_lvl <= ~osc_lvl;
         end
         else
            osc_cnt <= osc_cnt + 11'h001;
         // debounce always counts oscillator edges, even with an external clock
         if (osc_lvl & ~osc_prev)
         begin
            if (deb_cnt == DEB_LAST)
            begin
               deb_cnt  <= 10'h000;
               deb_tick <= 1'b1;
            end
            else
               deb_cnt <= deb_cnt + 10'h001;
         end
      end
   end

   // selected timing clock edge and counter clear for the waveform generator
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sel_prev         <= 1'b0;
         TIMING_CLK_TICK  <= 1'b0;
         TIMING_CNT_CLEAR <= 1'b0;
      end
      else
      begin
         sel_prev         <= sel_lvl;
         TIMING_CLK_TICK  <= sel_lvl & ~sel_prev;
         TIMING_CNT_CLEAR <= ~hw_on & cfg_alert[`PICAL_C_CNTRST];
      end
   end

   // register writes; hardware reset blocks access and may restore ports
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         for (i = 0; i < 4; i = i + 1)
            port_reg[i] <= `PICAL_PORT_RST;
         cfg_alert <= `PICAL_CFGA_RST;
         cfg_clock <= `PICAL_CFGK_RST;
      end
      else if (!hw_on)
      begin
         for (i = 0; i < 4; i = i + 1)
            if (cfg_alert[`PICAL_C_PORTRST])
               port_reg[i] <= `PICAL_PORT_RST;
      end
      else if (REG_WR)
      begin
         for (i = 0; i < 4; i = i + 1)
            if (port_hit[i])
               port_reg[i] <= REG_WDATA;
         if (REG_ADDR == `PICAL_ADDR_CFG_ALERT)
            cfg_alert <= REG_WDATA[5:0];
         if (REG_ADDR == `PICAL_ADDR_CFG_CLOCK)
            cfg_clock <= REG_WDATA;
      end
   end

   // snapshot and per-port change flags
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         snap   <= 4'h0;
         change <= 4'h0;
      end
      else
      begin
         for (i_chg = 0; i_chg < 4; i_chg = i_chg + 1)
         begin
            // the whole read window tracks the input, so a change inside it is lost
            if (REG_RD & port_hit[i_chg] & hw_on)
            begin
               snap[i_chg]   <= det[i_chg];
               change[i_chg] <= 1'b0;
            end
            else if (is_in[i_chg] & (det[i_chg] != snap[i_chg]))
               change[i_chg] <= 1'b1;
         end
      end
   end

   // latching alert with deferral until stop while a read sequence runs
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         alert       <= 1'b0;
         defer       <= 4'h0;
         in_read_seq <= 1'b0;
         rd_q        <= 1'b0;
      end
      else
      begin
         rd_q <= REG_RD;
         if (stop_evt)
            in_read_seq <= 1'b0;
         else if (rd_rise & hw_on)
            in_read_seq <= 1'b1;
         // any port read releases the alert; hardware reset does not
         if (port_read & hw_on)
            alert <= 1'b0;
         for (i_alt = 0; i_alt < 4; i_alt = i_alt + 1)
            if (port_read & port_hit[i_alt])
               defer[i_alt] <= 1'b0;
         if (stop_evt)
         begin
            defer <= 4'h0;
            if (|defer)
               alert <= 1'b1;
         end
         // new events in a release cycle are deferred, as the read strobe is high
         if (|evt_mask)
         begin
            if ((in_read_seq & ~stop_evt) | REG_RD) // at stop the event fires at once
               defer <= defer | evt_mask;
            else
               alert <= 1'b1;
         end
      end
   end

   // read data, captured when the read window opens
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         REG_RDATA <= 8'h00;
      else if (rd_rise & hw_on)
      begin
         REG_RDATA <= 8'h00;
         for (i_rd = 0; i_rd < 4; i_rd = i_rd + 1)
            if (port_hit[i_rd])
            begin
               if (is_in[i_rd])
                  REG_RDATA <= {port_reg[i_rd][7:2], change[i_rd], det[i_rd]};
               else
                  REG_RDATA <= port_reg[i_rd];
            end
         if (REG_ADDR == `PICAL_ADDR_CFG_ALERT)
            REG_RDATA <= {~|change, ~alert, cfg_alert};
         if (REG_ADDR == `PICAL_ADDR_CFG_CLOCK)
            REG_RDATA <= cfg_clock;
      end
   end

   // pin drive: inputs float, outputs follow the waveform level
   reg [3:0] next_out, next_oe_n;
   always @*
   begin
      next_out  = 4'h0;
      next_oe_n = 4'hF;
      for (i_pin = 0; i_pin < 4; i_pin = i_pin + 1)
         if (!is_in[i_pin])
         begin
            next_out[i_pin] = PWM_LEVEL[i_pin];
            // port one is open drain only, others follow their push-pull bit
            if ((i_pin == 0) || !port_reg[i_pin][6])
               next_oe_n[i_pin] = PWM_LEVEL[i_pin];
            else
               next_oe_n[i_pin] = 1'b0;
         end
      // port three carries the selected timing clock
      if (clk_out)
      begin
         next_out[2]  = sel_lvl;
         next_oe_n[2] = 1'b0;
      end
      // port one pulls low while the alert is latched
      if (alert_sel)
      begin
         next_out[0]  = 1'b0;
         next_oe_n[0] = ~alert;
      end
   end

   // registered pin outputs
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         PORT_OUT  <= 4'h0;
         PORT_OE_N <= 4'hF;
      end
      else
      begin
         PORT_OUT  <= next_out;
         PORT_OE_N <= next_oe_n;
      end
   end

endmodule

// >>> pical_props.sv
// port-level checks of the input change logic
module pical_props (
   input wire       CLK,
   input wire       RST_N,
   input wire       HW_RST_N,
   input wire       BUS_HOLD_STOP,
   input wire [7:0] REG_ADDR,
   input wire       REG_WR,
   input wire [7:0] REG_WDATA,
   input wire       REG_RD,
   input wire [7:0] REG_RDATA,
   input wire [3:0] PORT_OE_N,
   input wire       TIMING_CLK_TICK,
   input wire       TIMING_CNT_CLEAR
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   reg  rd_q;
   reg  sel;
   wire rd_go = REG_RD && !rd_q && !BUS_HOLD_STOP;
   wire pin_rd = rd_go && sel && REG_ADDR >= 8'h01 && REG_ADDR <= 8'h04;

   // read edge finder and alert pin selection seen on accepted writes
   always @(posedge CLK or negedge RST_N)
      if (!RST_N)
      begin
         rd_q <= 1'b0;
         sel  <= 1'b0;
      end
      else
      begin
         rd_q <= REG_RD;
         if (REG_WR && !BUS_HOLD_STOP && REG_ADDR == 8'h27)
            sel <= REG_WDATA[0];
      end

   a_hold_on: assert property (!HW_RST_N [*3] |-> BUS_HOLD_STOP)
      else $error("bus not parked while hardware reset low");
   a_hold_off: assert property (HW_RST_N [*4] |-> !BUS_HOLD_STOP)
      else $error("bus still parked while enabled");
   a_rdata_stands: assert property (!rd_go |=> $stable(REG_RDATA))
      else $error("read data moved without a read");
   a_tick_pulse: assert property (TIMING_CLK_TICK |=> !TIMING_CLK_TICK)
      else $error("timing tick longer than one cycle");
   a_cnt_clear: assert property (TIMING_CNT_CLEAR |-> BUS_HOLD_STOP || $past(BUS_HOLD_STOP))
      else $error("counter clear outside hardware reset");
   a_alert_bit: assert property (rd_go && sel && REG_ADDR == 8'h26 |=> REG_RDATA[6] == PORT_OE_N[0])
      else $error("alert status bit differs from pin");
   a_no_reassert: assert property (sel && REG_RD && $past(REG_RD) |-> !$fell(PORT_OE_N[0]))
      else $error("alert asserted inside a read");
   a_alert_release: assert property (pin_rd |-> ##2 PORT_OE_N[0])
      else $error("alert not released by port read");
   c_cfg_read: cover property (rd_go && REG_ADDR == 8'h26);
   c_alert: cover property (sel && $fell(PORT_OE_N[0]));
   c_cnt_clear: cover property (TIMING_CNT_CLEAR);
endmodule

bind pical_top pical_props pical_props_inst (
   .CLK(CLK), .RST_N(RST_N), .HW_RST_N(HW_RST_N), .BUS_HOLD_STOP(BUS_HOLD_STOP),
   .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .PORT_OE_N(PORT_OE_N), .TIMING_CLK_TICK(TIMING_CLK_TICK),
   .TIMING_CNT_CLEAR(TIMING_CNT_CLEAR)
);

// >>> pical_host.sv
// host side model: register reads, writes and stop of the serial engine
module pical_host (
   input  wire       clk,
   input  wire [7:0] rdata,
   output reg  [7:0] addr,
   output reg        wr,
   output reg  [7:0] wdata,
   output reg        rd,
   output reg        stop
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus after power-up
   initial
   begin
      addr = 8'h00;
      wr = 1'b0;
      wdata = 8'h00;
      rd = 1'b0;
      stop = 1'b0;
   end

   // one strobe; data line then shows garbage, not the old value
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
   endtask

   // read window of five cycles, data picked up as it closes
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      repeat (5) @(posedge clk);
      rd <= 1'b0;
      d = rdata;
   endtask

   task automatic stop_seq;
      @(posedge clk);
      stop <= 1'b1;
      @(posedge clk);
      stop <= 1'b0;
   endtask

   // alert service: config first, then all ports as one burst
   task automatic service(output logic [7:0] g);
      logic [7:0] x;
      rd_reg(8'h26, g);
      for (int i = 1; i <= 4; i++)
         rd_reg(i[7:0], x);
      stop_seq;
   endtask
endmodule

// >>> tb.sv
// self-checking bench of the input change logic
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       hw_rst_n = 1'b1;
   logic [3:0] pin = 4'h0;
   wire  [7:0] addr, wdata, rdata;
   wire        wr, rd, stop, hold, tick, cclr;
   wire  [3:0] pout, oe_n;
   logic [7:0] d;
   int         error_cnt = 0;
   int         tests_run = 0;
   int         ticks = 0;
   int         n0;

   always #5 clk = ~clk;

   // selected timing clock rises seen
   always @(posedge clk)
      if (tick)
         ticks <= ticks + 1;

   pical_top #(.DEB_TICKS(2)) pical_top_inst (
      .CLK(clk), .RST_N(rst_n), .HW_RST_N(hw_rst_n), .BUS_HOLD_STOP(hold),
      .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .BUS_STOP(stop),
      .REG_RDATA(rdata), .PORT_IN(pin), .PORT_OUT(pout), .PORT_OE_N(oe_n),
      .PWM_LEVEL(4'h0), .TIMING_CLK_TICK(tick), .TIMING_CNT_CLEAR(cclr));
   pical_host pical_host_inst (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr),
      .wdata(wdata), .rd(rd), .stop(stop));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic flip(input int b);
      @(posedge clk);
      pin[b] <= ~pin[b];
   endtask

   task automatic t_change;
      pical_host_inst.wr_reg(8'h27, 8'h01);
      pical_host_inst.wr_reg(8'h02, 8'hA0);
      pical_host_inst.rd_reg(8'h02, d);
      pical_host_inst.stop_seq;
      flip(1);
      cyc(6);
      chk({7'h0, oe_n[0]}, 8'h00);
      pical_host_inst.rd_reg(8'h26, d);
      chk(d & 8'hC0, 8'h00);
      pical_host_inst.rd_reg(8'h02, d);
      chk(d, 8'hA3);
      chk({7'h0, oe_n[0]}, 8'h01);
      pical_host_inst.stop_seq;
      pical_host_inst.rd_reg(8'h26, d);
      chk(d & 8'h80, 8'h80);
      pical_host_inst.stop_seq;
   endtask

   task automatic t_noint;
      flip(2);
      cyc(6);
      chk({7'h0, oe_n[0]}, 8'h01);
      pical_host_inst.service(d);
      chk(d & 8'h80, 8'h00);
      pical_host_inst.rd_reg(8'h26, d);
      chk(d & 8'h80, 8'h80);
      pical_host_inst.stop_seq;
   endtask

   task automatic t_output;
      pical_host_inst.wr_reg(8'h04, 8'h00);
      flip(3);
      cyc(6);
      pical_host_inst.rd_reg(8'h26, d);
      chk(d & 8'hC0, 8'hC0);
      pical_host_inst.rd_reg(8'h04, d);
      chk(d, 8'h00);
      pical_host_inst.stop_seq;
   endtask

   task automatic t_defer;
      pical_host_inst.rd_reg(8'h02, d);
      flip(1);
      cyc(6);
      chk({7'h0, oe_n[0]}, 8'h01);
      pical_host_inst.stop_seq;
      cyc(2);
      chk({7'h0, oe_n[0]}, 8'h00);
      pical_host_inst.rd_reg(8'h02, d);
      flip(1);
      cyc(6);
      pical_host_inst.rd_reg(8'h02, d);
      pical_host_inst.stop_seq;
      cyc(3);
      chk({7'h0, oe_n[0]}, 8'h01);
   endtask

   task automatic t_blind;
      fork
         pical_host_inst.rd_reg(8'h03, d);
         flip(2);
      join
      pical_host_inst.rd_reg(8'h03, d);
      chk(d & 8'h03, {7'h0, pin[2]});
      pical_host_inst.stop_seq;
   endtask

   task automatic t_debounce;
      pical_host_inst.wr_reg(8'h02, 8'hA4);
      cyc(14000);
      pical_host_inst.rd_reg(8'h02, d);
      pical_host_inst.stop_seq;
      flip(1);
      cyc(100);
      flip(1);
      cyc(14000);
      pical_host_inst.rd_reg(8'h02, d);
      chk(d & 8'h03, {7'h0, pin[1]});
      flip(1);
      cyc(4);
      pical_host_inst.rd_reg(8'h02, d);
      chk(d & 8'h01, {7'h0, ~pin[1]});
      pical_host_inst.stop_seq;
      cyc(14000);
      chk({7'h0, oe_n[0]}, 8'h00);
      pical_host_inst.rd_reg(8'h02, d);
      chk(d, {7'h53, pin[1]});
      pical_host_inst.stop_seq;
   endtask

   task automatic t_hwrst;
      pical_host_inst.wr_reg(8'h26, 8'h03);
      pical_host_inst.wr_reg(8'h03, 8'h84);
      pical_host_inst.wr_reg(8'h02, 8'hA0);
      pical_host_inst.rd_reg(8'h02, d);
      pical_host_inst.stop_seq;
      flip(1);
      cyc(6);
      hw_rst_n <= 1'b0;
      cyc(6);
      chk({7'h0, oe_n[0]}, 8'h00);
      chk({6'h0, hold, cclr}, 8'h03);
      pical_host_inst.wr_reg(8'h27, 8'h00);
      hw_rst_n <= 1'b1;
      cyc(4);
      pical_host_inst.rd_reg(8'h03, d);
      chk(d & 8'hFC, 8'h80);
      pical_host_inst.rd_reg(8'h27, d);
      chk(d, 8'h01);
      pical_host_inst.stop_seq;
   endtask

   task automatic t_clk;
      pical_host_inst.wr_reg(8'h27, 8'h0D);
      pin[1] <= 1'b0;
      cyc(10);
      n0 = ticks;
      repeat (10)
      begin
         cyc(8);
         chk({6'h0, pout[2], oe_n[2]}, 8'h00);
         pin[1] <= 1'b1;
         cyc(5);
         chk({6'h0, pout[2], oe_n[2]}, 8'h02);
         cyc(3);
         pin[1] <= 1'b0;
      end
      cyc(10);
      chk(8'(ticks - n0), 8'h0A);
   endtask

   // main sequence after a held power-on reset
   initial
   begin
      cyc(8);
      rst_n <= 1'b1;
      cyc(3);
      t_change;
      t_noint;
      t_output;
      t_defer;
      t_blind;
      t_debounce;
      t_hwrst;
      t_clk;
      finish_test;
   end

   // watchdog well past the roughly 45000 cycles the run needs
   initial
   begin
      #800000;
      error_cnt++;
      finish_test;
   end
endmodule
